// *** gsc_map.vh ***
`ifndef GSC_MAP_VH
`define GSC_MAP_VH

// Register byte offsets on the APB bus.
`define GSC_OFS_COUNT_LOW 12'h000
`define GSC_OFS_COUNT_HIGH 12'h004
`define GSC_OFS_COUNTER_CTRL 12'h008
`define GSC_OFS_GATE_CTRL 12'h00C
`define GSC_OFS_IRQ_STATUS 12'h010
`define GSC_OFS_IRQ_MASK 12'h014

// Counter control field positions.
`define GSC_CC_RUN 0
`define GSC_CC_EXT_CLK 1
`define GSC_CC_SYNC_DIS 2
`define GSC_CC_PRESCALE_LO 4
`define GSC_CC_PRESCALE_HI 5

// Gate control field positions.
`define GSC_GC_SRC_LO 0
`define GSC_GC_SRC_HI 1
`define GSC_GC_CMP_SYNC 2
`define GSC_GC_GATE_STATE 3
`define GSC_GC_POLARITY 6
`define GSC_GC_ENABLE 7

// Interrupt status and mask bit positions.
`define GSC_IRQ_OVF 0

// Writable bits of the two control registers.
`define GSC_CC_WR_MASK 8'h37
`define GSC_GC_WR_MASK 8'hC7

// Peer timer end values that mark its wrap.
`define GSC_PEER_MAX 8'hFF
`define GSC_PEER_ZERO 8'h00

// Gate source encodings.
`define GSC_SRC_PIN 2'b00
`define GSC_SRC_PEER 2'b01
`define GSC_SRC_CMP1 2'b10
`define GSC_SRC_CMP2 2'b11

// Reset values.
`define GSC_RST_COUNT 16'h0000
`define GSC_RST_CTRL 8'h00
`define GSC_RST_PRESCALE 3'h0

`endif

// *** gsc_counter.v ***
`timescale 1ns/1ps
`default_nettype none
`include "gsc_map.vh"

module gsc_counter #(
   parameter COUNT_WIDTH = 16
) (
   // Clock and reset.
   input wire i_clk_sys,
   input wire i_arst_n,
   // APB slave.
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // Count clock, gate sources and sleep state.
   input wire i_count_clock,
   input wire i_gate_pin,
   input wire [7:0] i_peer_timer_count,
   input wire i_cmp_one_out,
   input wire i_cmp_two_out,
   input wire i_sleep,
   // Interrupt and wake outputs.
   output reg o_irq,
   output reg o_wake
);

   ////////////////////////////////////////////////////////////////////////////
   // Storage.

   // Count value and hidden prescale counter.
   reg [COUNT_WIDTH-1:0] count;
   reg [2:0] prescale_cnt;
   // Control registers.
   reg [7:0] counter_control_reg;
   reg [7:0] gate_control_reg;
   // Interrupt status and mask.
   reg irq_status;
   reg irq_mask;
   // Count clock synchroniser stages and edge history.
   reg clk_s1;
   reg clk_s2;
   reg clk_s3;
   reg clk_raw_d;
   // Comparator synchronisers.
   reg cmp1_s1;
   reg cmp1_s2;
   reg cmp2_s1;
   reg cmp2_s2;
   // Previous peer timer value for wrap detection.
   reg [7:0] peer_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Field decode.

   // Named views of the control fields used below.
   wire run = counter_control_reg[`GSC_CC_RUN];
   wire ext_clk = counter_control_reg[`GSC_CC_EXT_CLK];
   wire clk_prescale_sel_lo = counter_control_reg[`GSC_CC_PRESCALE_LO];
   wire [1:0] clk_prescale_sel = counter_control_reg[`GSC_CC_PRESCALE_HI:`GSC_CC_PRESCALE_LO];
   wire sync_disable = counter_control_reg[`GSC_CC_SYNC_DIS];
   wire gate_enable = gate_control_reg[`GSC_GC_ENABLE];
   wire gate_polarity = gate_control_reg[`GSC_GC_POLARITY];
   wire cmp_sync = gate_control_reg[`GSC_GC_CMP_SYNC];
   wire [1:0] gate_source_sel = gate_control_reg[`GSC_GC_SRC_HI:`GSC_GC_SRC_LO];

   // Bus transfer qualifiers: a write or read is taken at the access edge.
   // Qualifying with the registered ready keeps a stretched access phase
   // from acting twice on the same transfer.
   wire bus_access = i_psel & i_penable & o_pready;
   wire bus_wr = bus_access & i_pwrite;
   wire bus_rd = bus_access & ~i_pwrite;
   wire wr_low = bus_wr & (i_paddr == `GSC_OFS_COUNT_LOW);
   wire wr_high = bus_wr & (i_paddr == `GSC_OFS_COUNT_HIGH);

   // Maps an address to a decode hit for the mapped registers.
   function addr_hit;
      input [11:0] addr;
      begin
         addr_hit = (addr == `GSC_OFS_COUNT_LOW) | (addr == `GSC_OFS_COUNT_HIGH) |
                    (addr == `GSC_OFS_COUNTER_CTRL) | (addr == `GSC_OFS_GATE_CTRL) |
                    (addr == `GSC_OFS_IRQ_STATUS) | (addr == `GSC_OFS_IRQ_MASK);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Count clock edge detection.

   // Synchronised edge comes from the second and third stages only.
   wire edge_sync = clk_s2 & ~clk_s3;
   // Unsynchronised edge looks straight at the pin.
   // It saves two cycles of latency but leaves the pin unfiltered, so a
   // glitch on the pin can count once on this path.
   wire edge_async = i_count_clock & ~clk_raw_d;
   // sync bypass select. switching paths may drop or add one edge.
   wire ext_edge = sync_disable ? edge_async : edge_sync;
   // Internal source ticks every system clock.
   wire clk_tick = ext_clk ? ext_edge : 1'b1;

   // Registers the count clock through the synchroniser chain.
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         clk_s1 <= 1'b0;
         clk_s2 <= 1'b0;
         clk_s3 <= 1'b0;
         clk_raw_d <= 1'b0;
      end else begin
         clk_s1 <= i_count_clock;
         clk_s2 <= clk_s1;
         clk_s3 <= clk_s2;
         clk_raw_d <= i_count_clock;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gate source selection.

   // A stalled peer timer never shows the wrap, so with polarity 1 that gate stays shut.
   // peer wrap detection.
   wire peer_timer_wrap = (peer_prev == `GSC_PEER_MAX) & (i_peer_timer_count == `GSC_PEER_ZERO);
   wire cmp_one_g = cmp_sync ? cmp1_s2 : i_cmp_one_out;
   wire cmp_two_g = cmp_sync ? cmp2_s2 : i_cmp_two_out;
   reg gate_sig;

   always @* begin
      case (gate_source_sel)
         `GSC_SRC_PIN: begin
            gate_sig = i_gate_pin;
         end
         `GSC_SRC_PEER: begin
            gate_sig = peer_timer_wrap;
         end
         `GSC_SRC_CMP1: begin
            gate_sig = cmp_one_g;
         end
         default: begin
            gate_sig = cmp_two_g;
         end
      endcase
   end

   // polarity match test; gating off counts freely.
   wire gate_open = ~gate_enable | (gate_polarity == gate_sig);

   // Captures comparator and peer timer history.
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cmp1_s1 <= 1'b0;
         cmp1_s2 <= 1'b0;
         cmp2_s1 <= 1'b0;
         cmp2_s2 <= 1'b0;
         peer_prev <= 8'h00;
      end else begin
         cmp1_s1 <= i_cmp_one_out;
         cmp1_s2 <= cmp1_s1;
         cmp2_s1 <= i_cmp_two_out;
         cmp2_s2 <= cmp2_s1;
         peer_prev <= i_peer_timer_count;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and counter.

   // Only the unsynchronised external path may count while the core sleeps.
   // sleep stops all but async external mode.
   wire sleep_ok = ~i_sleep | (ext_clk & sync_disable);
   // edges only advance while gate open.
   wire advance = run & sleep_ok & gate_open & clk_tick;
   // The prescaler restarts from zero after each step, so the divide is exact.
   // terminal value is 2^sel - 1.
   wire [2:0] prescale_last = {clk_prescale_sel == 2'b11, clk_prescale_sel[1], clk_prescale_sel_lo |
                               clk_prescale_sel[1]};
   wire prescale_done = (prescale_cnt == prescale_last);
   wire count_step = advance & prescale_done;
   wire overflow = count_step & (&count);

   // Advances the prescaler and count, and applies count byte writes.
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count <= `GSC_RST_COUNT;
         prescale_cnt <= `GSC_RST_PRESCALE;
      end else begin
         if (wr_low | wr_high) begin
            prescale_cnt <= `GSC_RST_PRESCALE;
         end else if (advance) begin
            prescale_cnt <= prescale_done ? `GSC_RST_PRESCALE : prescale_cnt + 3'h1;
         end
         if (wr_low) begin
            count[7:0] <= i_pwdata[7:0];
         end else if (wr_high) begin
            count[15:8] <= i_pwdata[7:0];
         end else if (count_step) begin
            count <= count + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control, interrupt and wake registers.

   // Holds software control fields and the sticky overflow flag.
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         counter_control_reg <= `GSC_RST_CTRL;
         gate_control_reg <= `GSC_RST_CTRL;
         irq_status <= 1'b0;
         irq_mask <= 1'b0;
         o_irq <= 1'b0;
         o_wake <= 1'b0;
      end else begin
         if (bus_wr & (i_paddr == `GSC_OFS_COUNTER_CTRL)) begin
            // Unused bits stay zero so that they read back as zero.
            counter_control_reg <= i_pwdata[7:0] & `GSC_CC_WR_MASK;
         end
         if (bus_wr & (i_paddr == `GSC_OFS_GATE_CTRL)) begin
            // The gate-open bit is not stored; it is read live.
            gate_control_reg <= i_pwdata[7:0] & `GSC_GC_WR_MASK;
         end
         if (bus_wr & (i_paddr == `GSC_OFS_IRQ_MASK)) begin
            irq_mask <= i_pwdata[`GSC_IRQ_OVF];
         end
         if (overflow) begin
            irq_status <= 1'b1;
         end else if (bus_rd & (i_paddr == `GSC_OFS_IRQ_STATUS)) begin
            irq_status <= 1'b0;
         end
         // The interrupt also takes this cycle's overflow, so it rises in step
         // with the status flag rather than one cycle after it.
         o_irq <= (irq_status | overflow) & irq_mask;
         // Wake is one pulse; the sticky status keeps the cause.
         // unmasked overflow in sleep wakes.
         o_wake <= overflow & irq_mask & i_sleep;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB answer path.

   reg [31:0] next_prdata;

   always @* begin
      next_prdata = 32'h0000_0000;
      case (i_paddr)
         `GSC_OFS_COUNT_LOW: begin
            next_prdata[7:0] = count[7:0];
         end
         `GSC_OFS_COUNT_HIGH: begin
            next_prdata[7:0] = count[15:8];
         end
         `GSC_OFS_COUNTER_CTRL: begin
            next_prdata[7:0] = counter_control_reg;
         end
         `GSC_OFS_GATE_CTRL: begin
            next_prdata[7:0] = gate_control_reg | {4'h0, gate_open, 3'h0};
         end
         `GSC_OFS_IRQ_STATUS: begin
            next_prdata[`GSC_IRQ_OVF] = irq_status;
         end
         `GSC_OFS_IRQ_MASK: begin
            next_prdata[`GSC_IRQ_OVF] = irq_mask;
         end
         default: begin
            next_prdata = 32'h0000_0000;
         end
      endcase
   end

   // Freezing the data at setup keeps a count step during the access cycle
   // from tearing the byte that software sees.
   // Answers one cycle after setup; data is captured in the setup cycle.
   always @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_prdata <= 32'h0000_0000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= i_psel & ~i_penable;
         if (i_psel & ~i_penable) begin
            o_prdata <= next_prdata;
            o_pslverr <= ~addr_hit(i_paddr);
         end else begin
            o_pslverr <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// *** gsc_counter_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
// Checker on the top ports: bus answer, error and interrupt timing.
module gsc_counter_asserts (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_sleep,
   input wire logic o_irq,
   input wire logic o_wake
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   // A setup cycle and a decoded register address.
   wire logic setup = i_psel && !i_penable;
   wire logic mapped = (i_paddr < 12'h0018) && (i_paddr[1:0] == 2'b00);
   a_ready_after_setup: assert property (setup |=> o_pready && i_penable) else $error("no answer after setup");
   a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready held too long");
   a_ready_needs_setup: assert property (o_pready |-> $past(setup)) else $error("ready without setup");
   a_err_unmapped: assert property (setup && !mapped |=> o_pslverr) else $error("unmapped not refused");
   a_err_mapped_none: assert property (setup && mapped |=> !o_pslverr) else $error("mapped refused");
   a_err_reads_zero: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0000_0000)
      else $error("refused read not zero");
   a_mask_off_irq: assert property (o_pready && i_pwrite && i_paddr == 12'h014 && !i_pwdata[0] |-> ##2 !o_irq)
      else $error("irq with mask off");
   a_wake_in_sleep: assert property (o_wake |-> $past(i_sleep) || $past(i_sleep, 2))
      else $error("wake while awake");
   a_wake_one_pulse: assert property (o_wake |=> !o_wake) else $error("wake longer than a cycle");
endmodule
`default_nettype wire

// *** gsc_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far side: external count clock and the peer 8-bit timer.
module gsc_far_side (
   input wire logic i_clk_sys,
   input wire logic i_ext_run,
   input wire logic i_peer_run,
   output logic o_count_clock = 1'b0,
   output logic [7:0] o_peer_timer_count = 8'h00
);
   logic [1:0] div = 2'd0;
   always @(posedge i_clk_sys) begin
      div <= (div == 2'd2 || !i_ext_run) ? 2'd0 : div + 2'd1;
      o_count_clock <= i_ext_run && (o_count_clock ^ (div == 2'd2));
      o_peer_timer_count <= o_peer_timer_count + {7'h00, i_peer_run};
   end
endmodule
`default_nettype wire

// *** gsc_counter_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module gsc_counter_tb;
   logic i_clk_sys = 0, i_arst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, rerr, woke = 0;
   logic i_gate_pin = 0, i_cmp_one_out = 0, i_cmp_two_out = 0, i_sleep = 0, ext_run = 0, peer_run = 0;
   logic [11:0] i_paddr = 0;
   logic [31:0] i_pwdata = 0, rdat;
   wire logic [31:0] o_prdata;
   wire logic o_pready, o_pslverr, o_irq, o_wake, i_count_clock;
   wire logic [7:0] i_peer_timer_count;
   int fails = 0, total_checks = 0, edges = 0;
   gsc_counter i_gsc_counter (.i_clk_sys, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_count_clock, .i_gate_pin, .i_peer_timer_count, .i_cmp_one_out,
      .i_cmp_two_out, .i_sleep, .o_irq, .o_wake);
   gsc_far_side u_far (.i_clk_sys, .i_ext_run(ext_run), .i_peer_run(peer_run), .o_count_clock(i_count_clock),
      .o_peer_timer_count(i_peer_timer_count));
   initial forever #2 i_clk_sys = ~i_clk_sys;
   always @(posedge i_count_clock) edges++;
   always @(posedge i_clk_sys) if (o_wake === 1'b1) woke <= 1'b1;
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   // One bus transfer; waits for ready under a bound.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      t = 0;
      i_psel <= 1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk_sys);
      i_penable <= 1;
      do begin
         @(posedge i_clk_sys);
         t++;
      end while (o_pready !== 1'b1 && t < 50);
      if (t >= 50) begin
         check("ready", 0, 1);
         stop_test;
      end
      rdat = o_prdata;
      rerr = o_pslverr;
      i_psel <= 0;
      i_penable <= 0;
      @(posedge i_clk_sys);
   endtask
   // Stops the counter and loads both count bytes.
   // stop before loading.
   task automatic preset(input logic [15:0] v);
      apb(1, 12'h008, 32'h0000_0000);
      apb(1, 12'h000, {24'h0, v[7:0]});
      apb(1, 12'h004, {24'h0, v[15:8]});
   endtask
   // pair read only while no count clock edges arrive.
   task automatic rd16(output logic [15:0] v);
      apb(0, 12'h000, 32'h0000_0000);
      v[7:0] = rdat[7:0];
      apb(0, 12'h004, 32'h0000_0000);
      v[15:8] = rdat[7:0];
   endtask
   task automatic run(input logic [7:0] c, input int n);
      apb(1, 12'h008, {24'h0, c});
      repeat (n) @(posedge i_clk_sys);
      apb(1, 12'h008, 32'h0000_0000);
   endtask
   task automatic t_reset;
      for (int a = 0; a < 24; a += 4) begin
         apb(0, a[11:0], 32'h0000_0000);
         check("reset value", rdat & 32'hFFFF_FFF7, 0);
      end
      apb(1, 12'h020, 32'h0000_00FF);
      apb(0, 12'h020, 32'h0000_0000);
      check("unmapped error", rerr, 1);
      check("unmapped data", rdat, 0);
      $display("test reset done");
   endtask
   task automatic t_prescale;
      logic [15:0] v;
      for (int s = 0; s < 4; s++) begin
         preset(16'h0000);
         run({2'b00, s[1:0], 4'h1}, 62);
         rd16(v);
         check("prescale", v >= (65 >> s) - 1 && v <= (65 >> s) + 1, 1);
      end
      $display("test prescale done");
   endtask
   task automatic t_gate;
      logic [15:0] v;
      logic l;
      for (int s = 0; s < 4; s++) for (int p = 0; p < 2; p++) begin
         l = (s != 1);
         i_gate_pin <= (s == 0) ? l : !l;
         i_cmp_one_out <= (s == 2) ? l : !l;
         i_cmp_two_out <= (s == 3) ? l : !l;
         preset(16'h0000);
         apb(1, 12'h00C, {24'h0, 1'b1, p[0], 3'b000, s == 3, s[1:0]});
         run(8'h01, 20);
         rd16(v);
         check("gate", v != 0, p[0] == l);
      end
      peer_run <= 1;
      preset(16'h0000);
      apb(1, 12'h00C, 32'h0000_00C1);
      run(8'h01, 600);
      rd16(v);
      check("peer wrap", v >= 2 && v <= 3, 1);
      peer_run <= 0;
      apb(1, 12'h00C, 32'h0000_0000);
      $display("test gate done");
   endtask
   task automatic t_ovf;
      logic [15:0] v;
      for (int m = 1; m >= 0; m--) begin
         apb(1, 12'h014, m);
         preset(16'hFFFE);
         run(8'h01, 4);
         check("irq", o_irq, m);
         rd16(v);
         check("wrap", v > 0 && v < 16'h0010, 1);
         apb(0, 12'h010, 32'h0000_0000);
         check("status", rdat[0], 1);
         apb(0, 12'h010, 32'h0000_0000);
         check("cleared", {rdat[0], o_irq}, 0);
      end
      $display("test overflow done");
   endtask
   task automatic t_ext;
      logic [15:0] v, w;
      apb(1, 12'h014, 32'h0000_0001);
      preset(16'hFFFE);
      i_sleep <= 1;
      apb(1, 12'h008, 32'h0000_0007);
      edges = 0;
      ext_run <= 1;
      repeat (60) @(posedge i_clk_sys);
      ext_run <= 0;
      repeat (8) @(posedge i_clk_sys);
      rd16(v);
      check("async count", v, 16'(16'hFFFE + edges[15:0]));
      check("wake", woke, 1);
      apb(1, 12'h008, 32'h0000_0003);
      ext_run <= 1;
      repeat (60) @(posedge i_clk_sys);
      ext_run <= 0;
      repeat (8) @(posedge i_clk_sys);
      rd16(w);
      check("sleep hold", w, v);
      i_sleep <= 0;
      edges = 0;
      ext_run <= 1;
      repeat (60) @(posedge i_clk_sys);
      ext_run <= 0;
      repeat (8) @(posedge i_clk_sys);
      rd16(w);
      check("sync count", w, 16'(v + edges[15:0]));
      $display("test external done");
   endtask
   // Resets in mid-run with the count running and an interrupt pending.
   task automatic t_rerun;
      logic [15:0] v;
      preset(16'h1234);
      apb(1, 12'h008, 32'h0000_0031);
      repeat (5) @(posedge i_clk_sys);
      i_arst_n <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      @(posedge i_clk_sys);
      check("reset irq", o_irq, 0);
      rd16(v);
      check("reset count", v, 0);
      apb(0, 12'h008, 32'h0000_0000);
      check("reset control", rdat, 0);
      $display("test mid-run reset done");
   endtask
   task automatic stop_test;
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #100us;
      fails++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge i_clk_sys);
      i_arst_n <= 1'b1;
      @(posedge i_clk_sys);
      t_reset;
      t_prescale;
      t_gate;
      t_ovf;
      t_ext;
      t_rerun;
      stop_test;
   end
endmodule
bind gsc_counter gsc_counter_asserts i_chk (.i_clk_sys, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sleep, .o_irq, .o_wake);
`default_nettype wire
